// File: rtl/acs_defs.svh
// Offsets, field positions, reset values and widths of the analog select control.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
`define ACS_ADDR_W          16
`define ACS_IDX_W           14
`define ACS_IDX_STATUS_CTL  14'h001e
`define ACS_IDX_CONFIG_OPT  14'h1ff0
`define ACS_IDX_ANALOG_MUX  14'h001c
`define ACS_IDX_ANALOG_CTL  14'h001d
`define ACS_RESP_OKAY       2'h0
`define ACS_RESP_SLVERR     2'h2
`define ACS_RST_BYTE        8'h00
`define ACS_MUX_CHAN_LO     0
`define ACS_MUX_CHAN_HI     3
`define ACS_MUX_VREF        4
`define ACS_MUX_HOLD        5
`define ACS_MUX_DIVIDED_HOLD       6
`define ACS_MUX_MASK        8'h7f
`define ACS_ACR_CHG         0
`define ACS_ACR_METH_A      1
`define ACS_ACR_METH_B      2
`define ACS_ACR_CURRENT_SOURCE_ENABLE        3
`define ACS_ACR_MASK        8'h0f
`define ACS_ASR_COMPARATOR_ONE_OUT_ENABLE        0
`define ACS_ASR_SAMPLE_OFFSET_ENABLE        1
`define ACS_ASR_AIE         2
`define ACS_ASR_FLAG_LO     4
`define ACS_ASR_CMP_LO      6
`define ACS_ASR_CTL_MASK    8'h07
`define ACS_CONFIG_OPTION_BYTE_OPT        0
`define ACS_NUM_CMP         2
`endif

// File: rtl/acs_pkg.sv
// Types shared by the analog select control modules.
// Assumes the constants header is on the include path.
`include "acs_defs.svh"
package acs_pkg;
  typedef logic [`ACS_IDX_W-1:0] acs_idx_type;
  typedef struct packed {
    logic        aw_have;
    logic        w_have;
    acs_idx_type aw_idx;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
  } acs_axi_type;
endpackage : acs_pkg

// File: rtl/acs_reg_if.sv
// Register access carrier between the bus slave and the control core.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface acs_reg_if;
  import acs_pkg::*;
  logic        wr_en;
  acs_idx_type wr_idx;
  logic [7:0]  wr_data;
  logic        wr_ok;
  acs_idx_type rd_idx;
  logic [7:0]  rd_data;
  logic        rd_ok;
  modport slave (output wr_en, wr_idx, wr_data, rd_idx, input wr_ok, rd_data, rd_ok);
  modport core  (input wr_en, wr_idx, wr_data, rd_idx, output wr_ok, rd_data, rd_ok);
endinterface : acs_reg_if

// File: rtl/acs_axi_slave.sv
// AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes one clock with a synchronous active-high reset.
`timescale 1ns/100ps
`include "acs_defs.svh"
module acs_axi_slave (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [`ACS_ADDR_W-1:0] awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`ACS_ADDR_W-1:0] araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  acs_reg_if.slave                    rif
);
  import acs_pkg::*;
  acs_axi_type s_q, s_d;
  logic        commit;

  assign awready     = ~s_q.aw_have & ~s_q.bvalid;
  assign wready      = ~s_q.w_have & ~s_q.bvalid;
  assign arready     = ~s_q.rvalid;
  assign commit      = s_q.aw_have & s_q.w_have;
  assign rif.wr_en   = commit & s_q.wstrb0;
  assign rif.wr_idx  = s_q.aw_idx;
  assign rif.wr_data = s_q.wdata;
  assign rif.rd_idx  = araddr[`ACS_ADDR_W-1:2];
  assign bvalid      = s_q.bvalid;
  assign bresp       = s_q.bresp;
  assign rvalid      = s_q.rvalid;
  assign rresp       = s_q.rresp;
  assign rdata       = {24'h000000, s_q.rdata};

  always_comb begin
    s_d = s_q;
    if (awvalid && awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_idx  = awaddr[`ACS_ADDR_W-1:2];
    end
    if (wvalid && wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = wdata[7:0];
      s_d.wstrb0 = wstrb[0];
    end
    // The write lands on the same edge that raises the response.
    if (commit) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = rif.wr_ok ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
    end else if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rif.rd_data;
      s_d.rresp  = rif.rd_ok ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
    end else if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : acs_axi_slave

// File: rtl/acs_analog_ctl.sv
// Control core of the ramp-type analog subsystem: channel and reference select,
// divider, temperature diode, current source and comparator output gating.
// Assumes comparator outputs arrive asynchronously; all else is on SYS_CLK.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "acs_defs.svh"
// Summary of operation
// - Reference bit set with channel field zero routes channel bus to supply.
// - Divided-hold bit with hold clear switches the sampled path to the half divider.
// - Channel field connects the channel bus to the named analog pins.
// - Comparators stay active in wait and may wake via analog interrupt.
// - In stop, comparators run but never raise the wake request directly.
// - Option and output-enable set: pin carries comparator, port data, timer OR.
// - Current-source enable clear disables charge source and discharge device.
// - With enable set, conversion logic may turn on the ramp discharge.
// - Charge source drives when enabled, method zero and charge bit set.
// - Hold and divided-hold both set selects the temperature diode.
// - Temperature diode bias is powered only while the diode is selected.
// - Offset active with option set is steered by the hold bits.
module acs_analog_ctl (
  input  wire logic                   SYS_CLK,
  input  wire logic                   RESET,
  input  wire logic [`ACS_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                   S_AXI_AWVALID,
  output logic                        S_AXI_AWREADY,
  input  wire logic [31:0]            S_AXI_WDATA,
  input  wire logic [3:0]             S_AXI_WSTRB,
  input  wire logic                   S_AXI_WVALID,
  output logic                        S_AXI_WREADY,
  output logic [1:0]                  S_AXI_BRESP,
  output logic                        S_AXI_BVALID,
  input  wire logic                   S_AXI_BREADY,
  input  wire logic [`ACS_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                   S_AXI_ARVALID,
  output logic                        S_AXI_ARREADY,
  output logic [31:0]                 S_AXI_RDATA,
  output logic [1:0]                  S_AXI_RRESP,
  output logic                        S_AXI_RVALID,
  input  wire logic                   S_AXI_RREADY,
  input  wire logic                   CMP1_OUT,
  input  wire logic                   CMP2_OUT,
  input  wire logic                   STOP_MODE,
  input  wire logic                   DISCHARGE_REQ,
  input  wire logic                   PORTB4_DATA,
  input  wire logic                   PORTB4_DIR,
  input  wire logic                   TIMER_OUTPUT_LEVEL,
  output logic [3:0]                  CHANNEL_PIN_SEL,
  output logic                        SUPPLY_REF_SEL,
  output logic                        HALF_DIVIDER_SEL,
  output logic                        SAMPLE_HOLD_SEL,
  output logic                        TEMP_DIODE_SEL,
  output logic                        TEMP_BIAS_EN,
  output logic                        CHARGE_SOURCE_EN,
  output logic                        DISCHARGE_EN,
  output logic                        SAMPLE_OFFSET_EN,
  output logic                        CMP_PIN_O,
  output logic                        CMP_PIN_OE,
  output logic                        ANALOG_IRQ
);
  import acs_pkg::*;

  typedef struct packed {
    logic [7:0]              mux_reg;
    logic [7:0]              ctl_reg;
    logic [7:0]              asr_ctl;
    logic                    option_enable;
    logic [`ACS_NUM_CMP-1:0] sync1;
    logic [`ACS_NUM_CMP-1:0] sync2;
    logic [`ACS_NUM_CMP-1:0] prev;
    logic [`ACS_NUM_CMP-1:0] flags;
    logic [3:0]              chan;
    logic                    vref;
    logic                    half;
    logic                    hold;
    logic                    temp;
    logic                    bias;
    logic                    charge;
    logic                    dis;
    logic                    offset;
    logic                    pin_o;
    logic                    pin_oe;
    logic                    irq;
  } acs_core_type;

  acs_core_type c_q, c_d;
  acs_reg_if    rif ();

  logic [`ACS_NUM_CMP-1:0] cmp_raw;
  logic [`ACS_NUM_CMP-1:0] rise;
  logic                    wr_mux;
  logic                    wr_ctl;
  logic                    wr_asr;
  logic                    wr_opt;
  logic                    f_hold;
  logic                    f_divided_hold;
  logic                    f_current_source_enable;
  logic                    f_meth0;
  logic                    f_gate;

  // Decoding shared by the read and write paths.
  function automatic logic is_mapped(input acs_idx_type idx);
    is_mapped = (idx == `ACS_IDX_STATUS_CTL) || (idx == `ACS_IDX_CONFIG_OPT) ||
                (idx == `ACS_IDX_ANALOG_MUX) || (idx == `ACS_IDX_ANALOG_CTL);
  endfunction : is_mapped

  acs_axi_slave u_slave (
    .clk     (SYS_CLK),
    .rst     (RESET),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .rif     (rif.slave)
  );

  assign cmp_raw = {CMP2_OUT, CMP1_OUT};

  assign wr_mux = rif.wr_en && (rif.wr_idx == `ACS_IDX_ANALOG_MUX);
  assign wr_ctl = rif.wr_en && (rif.wr_idx == `ACS_IDX_ANALOG_CTL);
  assign wr_asr = rif.wr_en && (rif.wr_idx == `ACS_IDX_STATUS_CTL);
  assign wr_opt = rif.wr_en && (rif.wr_idx == `ACS_IDX_CONFIG_OPT);

  assign rif.wr_ok = is_mapped(rif.wr_idx);
  assign rif.rd_ok = is_mapped(rif.rd_idx);

  // Status reads show live comparator levels and the sticky edge flags.
  always_comb begin
    rif.rd_data = `ACS_RST_BYTE;
    unique case (rif.rd_idx)
      `ACS_IDX_ANALOG_MUX: rif.rd_data = c_q.mux_reg;
      `ACS_IDX_ANALOG_CTL: rif.rd_data = c_q.ctl_reg;
      `ACS_IDX_CONFIG_OPT: rif.rd_data[`ACS_CONFIG_OPTION_BYTE_OPT] = c_q.option_enable;
      `ACS_IDX_STATUS_CTL: begin
        rif.rd_data = c_q.asr_ctl;
        rif.rd_data[`ACS_ASR_FLAG_LO +: `ACS_NUM_CMP] = c_q.flags;
        rif.rd_data[`ACS_ASR_CMP_LO +: `ACS_NUM_CMP]  = c_q.sync2;
      end
      default: rif.rd_data = `ACS_RST_BYTE;
    endcase
  end

  assign rise = c_q.sync2 & ~c_q.prev;

  always_comb begin
    c_d = c_q;
    if (wr_mux) begin
      c_d.mux_reg = rif.wr_data & `ACS_MUX_MASK;
    end
    if (wr_ctl) begin
      c_d.ctl_reg = rif.wr_data & `ACS_ACR_MASK;
    end
    if (wr_asr) begin
      c_d.asr_ctl = rif.wr_data & `ACS_ASR_CTL_MASK;
    end
    if (wr_opt) begin
      c_d.option_enable = rif.wr_data[`ACS_CONFIG_OPTION_BYTE_OPT];
    end

    // Decoded here from the values about to be stored, so selects move with the write.
    f_hold  = c_d.mux_reg[`ACS_MUX_HOLD];
    f_divided_hold = c_d.mux_reg[`ACS_MUX_DIVIDED_HOLD];
    f_current_source_enable  = c_d.ctl_reg[`ACS_ACR_CURRENT_SOURCE_ENABLE];
    f_meth0 = ~c_d.ctl_reg[`ACS_ACR_METH_A] & ~c_d.ctl_reg[`ACS_ACR_METH_B];
    f_gate  = c_d.option_enable & c_d.asr_ctl[`ACS_ASR_COMPARATOR_ONE_OUT_ENABLE];

    // Comparators keep running in every mode; only the first stage sees the pin.
    c_d.sync1 = cmp_raw;
    c_d.sync2 = c_q.sync1;
    c_d.prev  = c_q.sync2;

    for (int i = 0; i < `ACS_NUM_CMP; i++) begin
      if (wr_asr && rif.wr_data[`ACS_ASR_FLAG_LO + i]) begin
        c_d.flags[i] = 1'b0;
      end
      if (rise[i]) begin
        c_d.flags[i] = 1'b1;
      end
    end

    c_d.chan = c_d.mux_reg[`ACS_MUX_CHAN_HI:`ACS_MUX_CHAN_LO];
    c_d.vref = c_d.mux_reg[`ACS_MUX_VREF] &&
               (c_d.mux_reg[`ACS_MUX_CHAN_HI:`ACS_MUX_CHAN_LO] == 4'h0);
    c_d.temp = f_hold & f_divided_hold;
    c_d.bias = f_hold & f_divided_hold;
    c_d.half = f_divided_hold & ~f_hold;
    c_d.hold = f_hold & ~f_divided_hold;

    c_d.offset = c_d.option_enable & c_d.asr_ctl[`ACS_ASR_SAMPLE_OFFSET_ENABLE] & (f_hold ^ f_divided_hold);

    c_d.charge = f_current_source_enable & f_meth0 & c_d.ctl_reg[`ACS_ACR_CHG];
    c_d.dis    = f_current_source_enable & DISCHARGE_REQ & ~c_d.charge;

    c_d.pin_o  = f_gate ? (c_q.sync2[0] | PORTB4_DATA | TIMER_OUTPUT_LEVEL) : PORTB4_DATA;
    c_d.pin_oe = f_gate | PORTB4_DIR;

    c_d.irq = c_d.asr_ctl[`ACS_ASR_AIE] & (|c_d.flags) & ~STOP_MODE;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign CHANNEL_PIN_SEL  = c_q.chan;
  assign SUPPLY_REF_SEL   = c_q.vref;
  assign HALF_DIVIDER_SEL = c_q.half;
  assign SAMPLE_HOLD_SEL  = c_q.hold;
  assign TEMP_DIODE_SEL   = c_q.temp;
  assign TEMP_BIAS_EN     = c_q.bias;
  assign CHARGE_SOURCE_EN = c_q.charge;
  assign DISCHARGE_EN     = c_q.dis;
  assign SAMPLE_OFFSET_EN = c_q.offset;
  assign CMP_PIN_O        = c_q.pin_o;
  assign CMP_PIN_OE       = c_q.pin_oe;
  assign ANALOG_IRQ       = c_q.irq;
endmodule : acs_analog_ctl

// File: tb/acs_far_model.sv
// Far side: the two comparators and the ramp capacitor on the ramp pin.
// Assumes the charge and discharge enables arrive on the bench clock.
`timescale 1ns/100ps
module acs_far_model #(
  parameter int TRIP = 100
) (
  input  wire logic clk,
  input  wire logic charge_en,
  input  wire logic discharge_en,
  input  wire logic cmp1_level,
  output logic      cmp1_out,
  output logic      cmp2_out
);
  int ramp = 0;
  always @(posedge clk) begin
    if (discharge_en) ramp <= 0;
    else if (charge_en && ramp < 255) ramp <= ramp + 1;
  end
  assign cmp2_out = ramp > TRIP;
  assign cmp1_out = cmp1_level;
endmodule : acs_far_model

// File: tb/acs_ctl_props.sv
// Checker of the analog select control at its top-level ports.
// Assumes it is bound into the top module and sees only its ports.
`timescale 1ns/100ps
module acs_ctl_props (
  input wire logic       SYS_CLK,
  input wire logic       RESET,
  input wire logic       S_AXI_AWVALID,
  input wire logic       S_AXI_AWREADY,
  input wire logic       S_AXI_WVALID,
  input wire logic       S_AXI_WREADY,
  input wire logic       S_AXI_BVALID,
  input wire logic       S_AXI_ARVALID,
  input wire logic       S_AXI_ARREADY,
  input wire logic       S_AXI_RVALID,
  input wire logic       STOP_MODE,
  input wire logic       DISCHARGE_REQ,
  input wire logic [3:0] CHANNEL_PIN_SEL,
  input wire logic       SUPPLY_REF_SEL,
  input wire logic       HALF_DIVIDER_SEL,
  input wire logic       SAMPLE_HOLD_SEL,
  input wire logic       TEMP_DIODE_SEL,
  input wire logic       TEMP_BIAS_EN,
  input wire logic       CHARGE_SOURCE_EN,
  input wire logic       DISCHARGE_EN,
  input wire logic       CMP_PIN_OE,
  input wire logic       ANALOG_IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  a_bias_with_diode: assert property (TEMP_BIAS_EN == TEMP_DIODE_SEL)
    else $error("diode bias differs from diode select");
  a_diode_path_only: assert property (TEMP_DIODE_SEL |-> !HALF_DIVIDER_SEL && !SAMPLE_HOLD_SEL)
    else $error("diode selected together with another path");
  a_ref_zero_chan: assert property (SUPPLY_REF_SEL |-> CHANNEL_PIN_SEL == 4'h0)
    else $error("supply reference with a channel pin");
  a_charge_excl: assert property (!(CHARGE_SOURCE_EN && DISCHARGE_EN))
    else $error("charge source and discharge both on");
  a_discharge_cause: assert property ($rose(DISCHARGE_EN) |-> $past(DISCHARGE_REQ))
    else $error("discharge without request");
  a_stop_no_wake: assert property ($past(STOP_MODE) |-> !ANALOG_IRQ)
    else $error("wake request in stop");
  a_select_on_write: assert property ($changed(CHANNEL_PIN_SEL) |-> $rose(S_AXI_BVALID))
    else $error("channel changed outside a write");
  a_quiet_release: assert property ($fell(RESET) |-> !ANALOG_IRQ && !CMP_PIN_OE
    && !DISCHARGE_EN && CHANNEL_PIN_SEL == 4'h0)
    else $error("output active after reset");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read response late");
  c_diode: cover property (TEMP_DIODE_SEL);
  c_charge: cover property (CHARGE_SOURCE_EN);
  c_discharge: cover property (DISCHARGE_EN);
  c_irq: cover property (ANALOG_IRQ);
endmodule : acs_ctl_props
bind acs_analog_ctl acs_ctl_props i_acs_ctl_props (.SYS_CLK, .RESET, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARVALID,
  .S_AXI_ARREADY, .S_AXI_RVALID, .STOP_MODE, .DISCHARGE_REQ, .CHANNEL_PIN_SEL,
  .SUPPLY_REF_SEL, .HALF_DIVIDER_SEL, .SAMPLE_HOLD_SEL, .TEMP_DIODE_SEL, .TEMP_BIAS_EN,
  .CHARGE_SOURCE_EN, .DISCHARGE_EN, .CMP_PIN_OE, .ANALOG_IRQ);

// File: tb/tb.sv
// Bench for the analog select control: bus tasks and directed sequences.
// Assumes the far-side model and the bound checker are compiled with it.
`timescale 1ns/100ps
`include "acs_defs.svh"
module tb;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic        stop = 0, dreq = 0, pb_data = 0, pb_dir = 0, tlvl = 0, lvl1 = 0;
  logic [15:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  chan;
  logic [1:0]  bresp, rresp;
  logic        awrdy, wrdy, bvalid, arrdy, rvalid, c1, c2, sref, half, shold, tdio, tbias;
  logic        charge_enable, dis, offs, pin_o, pin_oe, irq;
  logic [15:0] regs [4] = '{16'h0070, 16'h0074, 16'h0078, 16'h7fc0};
  int          bad_count = 0, check_count = 0;
  wire  [7:0]  sel = {sref, half, shold, tdio, tbias, charge_enable, dis, offs};
  acs_analog_ctl i_acs_analog_ctl (.SYS_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .CMP1_OUT(c1), .CMP2_OUT(c2), .STOP_MODE(stop),
    .DISCHARGE_REQ(dreq), .PORTB4_DATA(pb_data), .PORTB4_DIR(pb_dir),
    .TIMER_OUTPUT_LEVEL(tlvl), .CHANNEL_PIN_SEL(chan), .SUPPLY_REF_SEL(sref),
    .HALF_DIVIDER_SEL(half), .SAMPLE_HOLD_SEL(shold), .TEMP_DIODE_SEL(tdio),
    .TEMP_BIAS_EN(tbias), .CHARGE_SOURCE_EN(charge_enable), .DISCHARGE_EN(dis),
    .SAMPLE_OFFSET_EN(offs), .CMP_PIN_O(pin_o), .CMP_PIN_OE(pin_oe), .ANALOG_IRQ(irq));
  acs_far_model i_acs_far_model (.clk(clk), .charge_en(charge_enable), .discharge_en(dis),
    .cmp1_level(lvl1), .cmp1_out(c1), .cmp2_out(c2));
  initial forever #5 clk = ~clk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw = awv & awrdy;
      w = wv & wrdy;
      @(posedge clk);
      if (aw) awv <= 1'b0;
      if (w) wv <= 1'b0;
    end while (awv | wv);
    do begin
      @(negedge clk);
      aw = bvalid;
      r = bresp;
    end while (!aw);
    @(posedge clk);
    bready <= 1'b0;
    chk("bresp", er, r);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    logic hit;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      hit = arrdy;
      @(posedge clk);
    end while (!hit);
    arv <= 1'b0;
    do begin
      @(negedge clk);
      hit = rvalid;
    end while (!hit);
    chk("rdata", e, rdata);
    chk("rresp", er, rresp);
    @(posedge clk);
    rready <= 1'b0;
  endtask : rd
  initial begin
    #200us;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[i]) rd(regs[i], 0, `ACS_RESP_OKAY);
    chk("selects", 0, sel);
    wr(16'h0004, 32'hff, `ACS_RESP_SLVERR);
    rd(16'h0004, 0, `ACS_RESP_SLVERR);
    for (int n = 0; n < 4; n++) begin
      wr(16'h0070, 32'h1 << n, `ACS_RESP_OKAY);
      chk("chan", 32'h1 << n, chan);
      rd(16'h0070, 32'h1 << n, `ACS_RESP_OKAY);
    end
    wr(16'h0070, 32'h18, `ACS_RESP_OKAY);
    chk("selects", 0, sel);
    wr(16'h0070, 32'h10, `ACS_RESP_OKAY);
    chk("selects", 8'h80, sel);
    wr(16'h7fc0, 32'h1, `ACS_RESP_OKAY);
    wr(16'h0078, 32'h2, `ACS_RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      wr(16'h0070, k << 5, `ACS_RESP_OKAY);
      chk("selects", {1'b0, k == 2, k == 1, k == 3, k == 3, 2'b00, k == 1 || k == 2}, sel);
    end
    wr(16'h0070, 32'h0, `ACS_RESP_OKAY);
    wr(16'h7fc0, 32'h0, `ACS_RESP_OKAY);
    wr(16'h0070, 32'h20, `ACS_RESP_OKAY);
    chk("selects", 8'h20, sel);
    wr(16'h0070, 32'h0, `ACS_RESP_OKAY);
    dreq <= 1'b1;
    for (int v = 0; v < 16; v++) begin
      wr(16'h0074, v, `ACS_RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("selects", {5'h0, v == 9, v[3] && v != 9, 1'b0}, sel);
    end
    wr(16'h0074, 32'h8, `ACS_RESP_OKAY);
    wr(16'h0078, 32'h34, `ACS_RESP_OKAY);
    stop <= 1'b1;
    wr(16'h0074, 32'h9, `ACS_RESP_OKAY);
    repeat (150) @(posedge clk);
    rd(16'h0078, 32'ha4, `ACS_RESP_OKAY);
    chk("irq", 0, irq);
    stop <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq", 1, irq);
    wr(16'h0078, 32'h24, `ACS_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    wr(16'h0074, 32'h0, `ACS_RESP_OKAY);
    chk("selects", 0, sel);
    dreq <= 1'b0;
    pb_dir <= 1'b1;
    wr(16'h7fc0, 32'h1, `ACS_RESP_OKAY);
    wr(16'h0078, 32'h1, `ACS_RESP_OKAY);
    for (int m = 0; m < 8; m++) begin
      lvl1 <= m[0];
      pb_data <= m[1];
      tlvl <= m[2];
      repeat (6) @(posedge clk);
      chk("pin", m != 0, pin_o);
    end
    pb_data <= 1'b0;
    wr(16'h0078, 32'h0, `ACS_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("pin", 0, pin_o);
    wr(16'h0078, 32'h1, `ACS_RESP_OKAY);
    wr(16'h7fc0, 32'h0, `ACS_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("pin", 0, pin_o);
    chk("pin_oe", 1, pin_oe);
    complete_run();
  end
endmodule : tb
